// file: hw/sip_pkg.sv
// package for the sensor two-wire slave port: constants, types, byte select
// assumes nothing beyond a SystemVerilog elaborator
package sip_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned SIP_CORE_PERIOD_NS = 25;
  localparam int unsigned SIP_BUS_FREE_NS    = 2000;
  localparam int unsigned SIP_BUS_FREE_CYC   =
    (SIP_BUS_FREE_NS + SIP_CORE_PERIOD_NS - 1) / SIP_CORE_PERIOD_NS;
  localparam int unsigned SIP_FREE_W         = 7;

  ////////////////////////////////////////////////////////////////////////////
  // framing
  localparam logic [3:0] SIP_BYTE_BITS = 4'h8;
  localparam logic [6:0] SIP_OWN_ADDR  = 7'h28;
  localparam logic [2:0] SIP_IDX_LAST  = 3'h4;
  localparam logic [7:0] SIP_FILL_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [3:0]  SIP_CNT_RST  = 4'h0;
  localparam logic [7:0]  SIP_SH_RST   = 8'h00;
  localparam logic [2:0]  SIP_IDX_RST  = 3'h0;
  localparam logic [SIP_FREE_W-1:0] SIP_FREE_RST = 7'h00;

  ////////////////////////////////////////////////////////////////////////////
  // status codes
  localparam logic [1:0] SIP_ST_FRESH = 2'h0;
  localparam logic [1:0] SIP_ST_RSVD  = 2'h1;
  localparam logic [1:0] SIP_ST_STALE = 2'h2;
  localparam logic [1:0] SIP_ST_FAULT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [13:0] bridge;
    logic [10:0] temp;
  } sip_meas_s;

  typedef struct packed {
    logic [1:0] status;
    sip_meas_s  meas;
  } sip_pkt_s;

  typedef enum logic [2:0] {
    SIP_IDLE    = 3'h0,
    SIP_ADDR    = 3'h1,
    SIP_ACK_OUT = 3'h2,
    SIP_LOAD    = 3'h3,
    SIP_TX      = 3'h4,
    SIP_TX_ACK  = 3'h5,
    SIP_RX      = 3'h6,
    SIP_IGNORE  = 3'h7
  } sip_link_e;

  ////////////////////////////////////////////////////////////////////////////
  // byte of a read packet by index, fill beyond the fourth
  function automatic logic [7:0] sip_pkt_byte(input sip_pkt_s p,
                                              input logic [2:0] idx);
    logic [7:0] b;
    b = SIP_FILL_BYTE;
    unique case (idx)
      3'h0:    b = {p.status, p.meas.bridge[13:8]};
      3'h1:    b = p.meas.bridge[7:0];
      3'h2:    b = p.meas.temp[10:3];
      3'h3:    b = {p.meas.temp[2:0], 5'h00};
      default: b = SIP_FILL_BYTE;
    endcase
    return b;
  endfunction : sip_pkt_byte

endpackage : sip_pkg

// file: hw/sip_slave_port.sv
// two-wire slave port of a pressure and temperature sensor
// assumes an external master drives the clock line; pins resolved outside
module sip_slave_port
  import sip_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = SIP_OWN_ADDR
)(
  // core clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // link sampling clock
  input  wire logic      link_clk,
  // measurement source
  input  sip_meas_s      meas,
  input  wire logic      meas_new,
  input  wire logic      fault,
  // sensor status
  output logic           data_ready,
  output logic           bus_busy,
  // clock line
  input  wire logic      scl_level,
  output logic           scl_drv,
  output logic           scl_drv_en,
  // data line
  input  wire logic      sda_level,
  output logic           sda_drv,
  output logic           sda_drv_en
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic       link_rst;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  sip_link_e  state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       rw_q;
  logic       mack_q;
  logic [2:0] idx_q;
  logic       start_t_q;
  logic       stop_t_q;
  logic       req_t_q;
  logic       ack_s;
  logic       snap_ready;
  logic       byte_done;
  logic [2:0] ev_s;
  logic [2:0] ev_p_q;
  logic       start_p;
  logic       stop_p;
  logic       req_p;
  logic       busy_q;
  logic       counting_q;
  logic [SIP_FREE_W-1:0] free_q;
  logic       fresh_q;
  logic       drdy_q;
  logic       ack_t_q;
  sip_pkt_s   snap_q;
  logic [1:0] status_d;

  ////////////////////////////////////////////////////////////////////////////
  // crossings
  sip_sync2 #(.W(1)) u_rst_sync (
    .clk (link_clk),
    .d   (rst),
    .q   (link_rst)
  );

  // link clock far above 400 kHz so every line level is seen
  sip_sync2 #(.W(2)) u_pin_sync (
    .clk (link_clk),
    .d   ({scl_level, sda_level}),
    .q   (pins_s)
  );

  sip_sync2 #(.W(1)) u_ack_sync (
    .clk (link_clk),
    .d   (ack_t_q),
    .q   (ack_s)
  );

  sip_sync2 #(.W(3)) u_ev_sync (
    .clk (core_clk),
    .d   ({req_t_q, stop_t_q, start_t_q}),
    .q   (ev_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // line edges and conditions
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      scl_p_q <= '1;
      sda_p_q <= '1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_p_q;
  assign scl_fall   = ~scl_s & scl_p_q;
  assign start_ev   = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev    = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_done  = (cnt_q == SIP_BYTE_BITS);
  assign snap_ready = (ack_s == req_t_q);

  ////////////////////////////////////////////////////////////////////////////
  // link state machine
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      state_q <= SIP_IDLE;
    else if (start_ev)
      state_q <= SIP_ADDR;
    else if (stop_ev)
      state_q <= SIP_IDLE;
    else
    begin
      unique case (state_q)
        SIP_IDLE:    state_q <= SIP_IDLE;
        SIP_ADDR:
          if (scl_fall && byte_done)
            state_q <= (sh_q[7:1] == OWN_ADDR) ? SIP_ACK_OUT
                                               : SIP_IGNORE;
        SIP_ACK_OUT:
          if (scl_fall)
            state_q <= rw_q ? SIP_LOAD : SIP_RX;
        SIP_LOAD:
          if (snap_ready)
            state_q <= SIP_TX;
        SIP_TX:
          if (scl_fall && byte_done)
            state_q <= SIP_TX_ACK;
        SIP_TX_ACK:
          if (scl_fall)
            state_q <= mack_q ? SIP_TX : SIP_IGNORE;
        SIP_RX:
          if (scl_fall && byte_done)
            state_q <= SIP_ACK_OUT;
        SIP_IGNORE:  state_q <= SIP_IGNORE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit counter
  always_ff @(posedge link_clk)
  begin
    if (link_rst || start_ev || stop_ev)
      cnt_q <= SIP_CNT_RST;
    else if (scl_rise &&
             (state_q == SIP_ADDR || state_q == SIP_TX ||
              state_q == SIP_RX))
      cnt_q <= cnt_q + 4'h1;
    else if (scl_fall && byte_done)
      cnt_q <= SIP_CNT_RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register, direction and master acknowledge
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      sh_q   <= SIP_SH_RST;
      rw_q   <= '0;
      mack_q <= '0;
    end
    else
    begin
      if ((state_q == SIP_ADDR || state_q == SIP_RX) && scl_rise)
        sh_q <= {sh_q[6:0], sda_s};
      else if (state_q == SIP_LOAD && snap_ready)
        sh_q <= sip_pkt_byte(snap_q, SIP_IDX_RST);
      else if (state_q == SIP_TX && scl_fall && !byte_done)
        sh_q <= {sh_q[6:0], 1'b0};
      else if (state_q == SIP_TX_ACK && scl_fall)
        sh_q <= sip_pkt_byte(snap_q, idx_q);
      if (state_q == SIP_ADDR && scl_fall && byte_done)
        rw_q <= sh_q[0];
      if (state_q == SIP_TX_ACK && scl_rise)
        mack_q <= ~sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read byte index, saturating at the fill byte
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      idx_q <= SIP_IDX_RST;
    else if (state_q == SIP_LOAD && snap_ready)
      idx_q <= 3'h1;
    else if (state_q == SIP_TX_ACK && scl_fall && mack_q &&
             idx_q != SIP_IDX_LAST)
      idx_q <= idx_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // events toward the core
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      start_t_q <= '0;
      stop_t_q  <= '0;
      req_t_q   <= '0;
    end
    else
    begin
      if (start_ev)
        start_t_q <= ~start_t_q;
      if (stop_ev)
        stop_t_q <= ~stop_t_q;
      if (state_q == SIP_ACK_OUT && scl_fall && rw_q)
        req_t_q <= ~req_t_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pin drive
  assign scl_drv    = 1'b0;
  assign sda_drv    = 1'b0;
  assign scl_drv_en = (state_q == SIP_LOAD);
  // last data bit stands through its high phase, released after the 8th fall
  assign sda_drv_en = (state_q == SIP_ACK_OUT) ||
                      (state_q == SIP_TX && !sh_q[7]);

  ////////////////////////////////////////////////////////////////////////////
  // core side: events
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ev_p_q <= 3'h0;
    else
      ev_p_q <= ev_s;
  end

  assign start_p = ev_s[0] ^ ev_p_q[0];
  assign stop_p  = ev_s[1] ^ ev_p_q[1];
  assign req_p   = ev_s[2] ^ ev_p_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // core side: bus busy with bus-free delay
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      busy_q     <= '0;
      counting_q <= '0;
      free_q     <= SIP_FREE_RST;
    end
    else if (start_p)
    begin
      busy_q     <= '1;
      counting_q <= '0;
    end
    else if (stop_p)
    begin
      counting_q <= busy_q;
      free_q     <= SIP_FREE_RST;
    end
    else if (counting_q)
    begin
      if (free_q == SIP_FREE_W'(SIP_BUS_FREE_CYC - 1))
      begin
        busy_q     <= '0;
        counting_q <= '0;
      end
      else
        free_q <= free_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side: freshness, data ready and snapshot
  assign status_d = fault   ? SIP_ST_FAULT :
                    fresh_q ? SIP_ST_FRESH : SIP_ST_STALE;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fresh_q <= '0;
      drdy_q  <= '0;
    end
    else
    begin
      if (meas_new)
        fresh_q <= '1;
      else if (req_p)
        fresh_q <= '0;
      if (meas_new)
        drdy_q <= '1;
      else if (start_p)
        drdy_q <= '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      snap_q  <= '0;
      ack_t_q <= '0;
    end
    else if (req_p)
    begin
      snap_q  <= '{status: status_d, meas: meas};
      ack_t_q <= ~ack_t_q;
    end
  end

  assign data_ready = drdy_q;
  assign bus_busy   = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_start_decode: assert property (
    @(posedge link_clk) disable iff (link_rst)
    start_ev |=> state_q == SIP_ADDR && cnt_q == SIP_CNT_RST)
    else $error("start did not restart address decoding");

  chk_stop_idle: assert property (
    @(posedge link_clk) disable iff (link_rst)
    stop_ev && !start_ev |=> state_q == SIP_IDLE && !sda_drv_en)
    else $error("stop did not return the port to idle");

  chk_busy_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(counting_q) |-> busy_q [*8])
    else $error("bus freed too early after stop");

  chk_busy_start: assert property (
    @(posedge core_clk) disable iff (rst)
    start_p |=> busy_q && !counting_q)
    else $error("start did not mark the bus busy");

  chk_open_drain: assert property (
    @(posedge link_clk) disable iff (link_rst)
    !scl_drv && !sda_drv)
    else $error("line driven high");

  chk_byte_len: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == SIP_TX && !start_ev && !stop_ev && scl_fall && byte_done
    |=> state_q == SIP_TX_ACK && cnt_q == SIP_CNT_RST)
    else $error("byte ended after wrong bit count");

  chk_ack_release: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == SIP_TX_ACK || state_q == SIP_IGNORE |-> !sda_drv_en)
    else $error("data driven in master acknowledge slot");

  chk_stretch: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_q == SIP_LOAD && !snap_ready && !start_ev && !stop_ev
    |=> scl_drv_en)
    else $error("clock released before data was ready");

  chk_addr_match: assert property (
    @(posedge link_clk) disable iff (link_rst)
    $rose(state_q == SIP_ACK_OUT) && $past(state_q) == SIP_ADDR
    |-> $past(sh_q[7:1]) == OWN_ADDR && sda_drv_en)
    else $error("acknowledged a foreign address");

  chk_drdy_rise: assert property (
    @(posedge core_clk) disable iff (rst)
    meas_new |=> data_ready)
    else $error("data ready missed new data");

  chk_status_code: assert property (
    @(posedge core_clk) disable iff (rst)
    req_p |=> snap_q.status != SIP_ST_RSVD &&
              (snap_q.status == SIP_ST_FAULT) == $past(fault))
    else $error("wrong status code in snapshot");

endmodule : sip_slave_port

// file: hw/sip_sync2.sv
// two flip-flop synchroniser for levels and toggles
// assumes its input is stable long enough to be seen at the capturing clock
module sip_sync2
  import sip_pkg::*;
#(
  parameter int unsigned W = 1
)(
  // capturing clock
  input  wire logic         clk,
  // asynchronous input and synchronised output
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    meta_q <= d;
    q      <= meta_q;
  end

endmodule : sip_sync2

// file: tb/sensor_i2c_slave_port_test.sv
// self-checking bench of the sensor two-wire slave port
// assumes sip_pkg, sip_slave_port and the master model are compiled first
module sensor_i2c_slave_port_test
  import sip_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic      core_clk = 1'b0;
  logic      link_clk = 1'b0;
  logic      rst      = 1'b1;
  sip_meas_s meas     = '0;
  sip_meas_s cur      = '0;
  logic      meas_new = 1'b0;
  logic      fault    = 1'b0;
  logic      data_ready, bus_busy, scl_drv, scl_drv_en, sda_drv, sda_drv_en;
  logic      m_scl_en, m_sda_en, tmo, stretched, scl_level, sda_level;
  logic [1:0] st = 2'h0;
  logic [7:0] r;
  logic       ak;
  logic       held = 1'b0;
  int         seed = 32'h102a;
  int         fails = 0;
  int         n_compared = 0;

  always #12.5 core_clk = ~core_clk;
  always #16 link_clk = ~link_clk;

  // port pulled the clock line low at least once
  always @(posedge core_clk)
    if (scl_drv_en)
      held <= 1'b1;

  // wired-and with pull-ups
  assign scl_level = ~m_scl_en & (scl_drv_en ? scl_drv : 1'b1);
  assign sda_level = ~m_sda_en & (sda_drv_en ? sda_drv : 1'b1);

  sip_slave_port #(.OWN_ADDR(SIP_OWN_ADDR)) u_dut (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .meas(meas),
    .meas_new(meas_new), .fault(fault), .data_ready(data_ready),
    .bus_busy(bus_busy), .scl_level(scl_level), .scl_drv(scl_drv),
    .scl_drv_en(scl_drv_en), .sda_level(sda_level), .sda_drv(sda_drv),
    .sda_drv_en(sda_drv_en));

  sip_i2c_master u_mst (
    .clk(core_clk), .scl_level(scl_level), .sda_level(sda_level),
    .scl_en(m_scl_en), .sda_en(m_sda_en), .tmo(tmo),
    .stretched(stretched));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] exp_byte(input sip_meas_s m,
                                          input logic [1:0] s, input int i);
    case (i)
      0:       return {s, m.bridge[13:8]};
      1:       return m.bridge[7:0];
      2:       return m.temp[10:3];
      3:       return {m.temp[2:0], 5'h00};
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  // new measurement with a chosen fault level
  task automatic new_meas(input logic f);
    @(negedge core_clk);
    meas     = sip_meas_s'(25'($random(seed)));
    fault    = f;
    meas_new = 1'b1;
    @(negedge core_clk);
    meas_new = 1'b0;
    cur      = meas;
    st       = f ? SIP_ST_FAULT : SIP_ST_FRESH;
    @(negedge core_clk);
    check({7'h0, data_ready}, 8'h01);
  endtask : new_meas

  // start (or repeated start), address with read, nb bytes, stop
  task automatic do_read(input logic [6:0] a, input int nb);
    u_mst.start();
    check({6'h0, data_ready, bus_busy}, 8'h01);
    u_mst.xfer_byte({a, 1'b1}, 1'b0, r, ak);
    check({7'h0, ak}, {7'h0, a != SIP_OWN_ADDR});
    if (a == SIP_OWN_ADDR)
    begin
      for (int i = 0; i < nb; i++)
      begin
        u_mst.xfer_byte(8'hff, i < nb - 1, r, ak);
        check(i == 3 ? r & 8'he0 : r, exp_byte(cur, st, i));
      end
      if (st != SIP_ST_FAULT)
        st = SIP_ST_STALE;
    end
    u_mst.stop();
    repeat (40) @(negedge core_clk);
    check({7'h0, bus_busy}, 8'h01);
    repeat (30) @(negedge core_clk);
    check({7'h0, bus_busy}, 8'h00);
    check({6'h0, stretched, tmo}, 8'h00);
  endtask : do_read

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check({2'h0, data_ready, bus_busy, scl_drv_en, sda_drv_en, scl_drv,
           sda_drv}, 8'h00);
    repeat (20) @(negedge core_clk);
    new_meas(1'b0);
    do_read(SIP_OWN_ADDR, 5);
    check({7'h0, held}, 8'h01);
    do_read(SIP_OWN_ADDR, 2);
    new_meas(1'b1);
    do_read(SIP_OWN_ADDR, 3);
    do_read(SIP_OWN_ADDR ^ 7'h01, 1);
    u_mst.start();
    u_mst.xfer_byte({SIP_OWN_ADDR ^ 7'h40, 1'b1}, 1'b0, r, ak);
    check({7'h0, ak}, 8'h01);
    do_read(SIP_OWN_ADDR, 1);
    u_mst.start();
    for (int i = 0; i < 3; i++)
    begin
      u_mst.xfer_byte(i == 0 ? {SIP_OWN_ADDR, 1'b0} : 8'($random(seed)),
                      1'b0, r, ak);
      check({7'h0, ak}, 8'h00);
    end
    u_mst.stop();
    for (int k = 0; k < 3; k++)
    begin
      new_meas(1'($random(seed)));
      do_read(SIP_OWN_ADDR, 1 + ($unsigned($random(seed)) % 5));
    end
    check({6'h0, scl_drv, sda_drv}, 8'h00);
    end_of_test();
  end

  initial
  begin
    repeat (95000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

endmodule : sensor_i2c_slave_port_test

// file: tb/sip_i2c_master.sv
// two-wire bus master model: pulls clock and data low or releases them
// assumes the bench resolves both wires with pull-ups and feeds them back
module sip_i2c_master
  import sip_pkg::*;
(
  // timing reference
  input  wire logic clk,
  // resolved wires
  input  wire logic scl_level,
  input  wire logic sda_level,
  // pull-low enables
  output logic      scl_en,
  output logic      sda_en,
  // status
  output logic      tmo,
  output logic      stretched
);
  timeunit 1ns;
  timeprecision 100ps;

  // quarter bit of 0.625 us: 400 kbit/s fast rate
  localparam int Q = 25;

  initial
  begin
    scl_en    = 1'b0;
    sda_en    = 1'b0;
    tmo       = 1'b0;
    stretched = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic q_wait();
    repeat (Q) @(negedge clk);
  endtask : q_wait

  // release clock and wait, bounded, while the slave holds it low
  task automatic scl_up();
    int n;
    n = 0;
    scl_en = 1'b0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!scl_level && n < 400);
    if (n > 1)
      stretched = 1'b1;
    if (!scl_level)
      tmo = 1'b1;
  endtask : scl_up

  // start or repeated start, always followed by clock pulses
  task automatic start();
    sda_en = 1'b0;
    q_wait();
    scl_up();
    q_wait();
    sda_en = 1'b1;
    q_wait();
    scl_en = 1'b1;
  endtask : start

  task automatic stop();
    q_wait();
    sda_en = 1'b1;
    q_wait();
    scl_up();
    q_wait();
    sda_en = 1'b0;
    q_wait();
  endtask : stop

  // one clock pulse: data set mid low phase, sampled mid high phase
  task automatic xfer_bit(input logic b, output logic s);
    q_wait();
    sda_en = ~b;
    q_wait();
    scl_up();
    q_wait();
    s = sda_level;
    q_wait();
    scl_en = 1'b1;
  endtask : xfer_bit

  // eight bits msb first, then the ninth pulse; a is 0 on acknowledge
  task automatic xfer_byte(input logic [7:0] d, input logic ack,
                           output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r[i]);
    xfer_bit(~ack, a);
  endtask : xfer_byte

endmodule : sip_i2c_master
